/* File: pkg/dwrr_pkg.sv */
// shared constants, states and carriers of the warm-reset refresh sequencer
// assumes a single 100 MHz controller clock that also paces the memory clock count
package dwrr_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_PS   = 10000;
	localparam int unsigned CLK_SETTLE_NS   = 100;
	localparam int unsigned CLK_SETTLE_CYC  = (CLK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned SETTLE_W        = 8;

	// ****************************************
	// refresh interval field
	// ****************************************
	localparam int unsigned REF_IVAL_W      = 16;
	localparam int unsigned REF_IVAL_LSB    = 0;
	localparam logic [15:0] REF_IVAL_RST    = 16'h0c30;

	// ****************************************
	// states and carriers
	// ****************************************
	typedef enum logic [2:0] {
		ST_RUN      = 3'b000,
		ST_SR_ENTER = 3'b001,
		ST_BYPASS   = 3'b010,
		ST_RELOCK   = 3'b011,
		ST_CLK_ON   = 3'b100,
		ST_SR_EXIT  = 3'b101
	} dwrr_state_type;

	typedef struct packed {
		logic sr_enter;
		logic sr_exit;
		logic refresh;
		logic clk_bypass;
		logic clk_en;
		logic ready;
	} dwrr_mem_ctl_type;

endpackage : dwrr_pkg

/* File: rtl/dwrr_refresh_timer.sv */
// refresh interval timer, one tick every nonzero programmed number plus one of memory clock cycles
// assumes run and interval come from logic on ref_clk
`timescale 1ns/1ps
module dwrr_refresh_timer #(
	parameter int unsigned IVAL_W = dwrr_pkg::REF_IVAL_W
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              run,
	input  wire logic [IVAL_W-1:0] interval,
	output logic                   tick
);
	import dwrr_pkg::*;

	typedef struct packed {
		logic [IVAL_W-1:0] cnt;
		logic              tick;
	} dwrr_timer_type;

	dwrr_timer_type r_reg;
	dwrr_timer_type r_next;

	// ****************************************
	// countdown
	// ****************************************
	always_comb begin
		r_next      = r_reg;
		r_next.tick = 1'b0;
		if (!run || interval == '0) begin
			r_next.cnt = interval;
		end else if (r_reg.cnt == '0) begin
			r_next.tick = 1'b1;
			r_next.cnt  = interval;
		end else if (r_reg.cnt > interval) begin
			// stale longer count cut to the new interval
			r_next.cnt = interval;
		end else begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;

	// ****************************************
	// checks
	// ****************************************
	tick_on_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		run && interval != '0 && r_reg.cnt == '0 |=> tick)
		else $error("refresh tick missing at interval end");
	no_tick_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!$past(run) |-> !tick)
		else $error("refresh tick while timer stopped");

endmodule : dwrr_refresh_timer

/* File: rtl/dwrr_warm_reset_seq.sv */
// warm-reset self-refresh and memory clock sequencer of the memory controller
// assumes warm_reset_n and pll_lock arrive asynchronously, refresh_interval from ref_clk logic
//
// Behaviour
// - hold 16-bit refresh interval in memory cycles
// - warm reset puts memory into self-refresh
// - clock switches to pll bypass during warm reset
// - release: leave self-refresh, clock back functional
// - interval reloaded at self-refresh exit, so no slow refresh after release
// - memory clock never below minimum frequency
// - memory clock stable after self-refresh exit
`timescale 1ns/1ps
module dwrr_warm_reset_seq #(
	parameter int unsigned IVAL_W     = dwrr_pkg::REF_IVAL_W,
	parameter int unsigned SETTLE_CYC = dwrr_pkg::CLK_SETTLE_CYC
) (
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	input  wire logic                      warm_reset_n,
	input  wire logic                      pll_lock,
	input  wire logic [IVAL_W-1:0]         refresh_interval,
	output dwrr_pkg::dwrr_mem_ctl_type     mem_ctl,
	output dwrr_pkg::dwrr_state_type       seq_state
);
	import dwrr_pkg::*;

	typedef struct packed {
		logic                  warm_s1;
		logic                  warm_s2;
		logic                  lock_s1;
		logic                  lock_s2;
		dwrr_state_type        st;
		logic [SETTLE_W-1:0]   settle;
		logic [IVAL_W-1:0]     ival;
		dwrr_mem_ctl_type      ctl;
	} dwrr_seq_type;

	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

	dwrr_seq_type r_reg;
	dwrr_seq_type r_next;
	logic         warm_active;
	logic         lock_ok;
	logic         tick;

	assign warm_active = ~r_reg.warm_s2;
	assign lock_ok     = r_reg.lock_s2;

	// ****************************************
	// refresh timer
	// ****************************************
	dwrr_refresh_timer #(
		.IVAL_W   (IVAL_W)
	) u_timer (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.run      (r_reg.ctl.ready),
		.interval (r_reg.ival),
		.tick     (tick)
	);

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		r_next         = r_reg;
		r_next.warm_s1 = warm_reset_n;
		r_next.warm_s2 = r_reg.warm_s1;
		r_next.lock_s1 = pll_lock;
		r_next.lock_s2 = r_reg.lock_s1;
		case (r_reg.st)
			ST_RUN: begin
				if (warm_active) begin
					r_next.st = ST_SR_ENTER;
				end
			end
			ST_SR_ENTER: begin
				r_next.st = ST_BYPASS;
			end
			ST_BYPASS: begin
				if (!warm_active) begin
					r_next.st = ST_RELOCK;
				end
			end
			ST_RELOCK: begin
				r_next.settle = '0;
				if (warm_active) begin
					r_next.st = ST_BYPASS;
				end else if (lock_ok) begin
					r_next.st = ST_CLK_ON;
				end
			end
			ST_CLK_ON: begin
				r_next.settle = r_reg.settle + 1'b1;
				if (warm_active) begin
					r_next.st = ST_BYPASS;
				end else if (!lock_ok) begin
					r_next.st = ST_RELOCK;
				end else if (r_reg.settle == SETTLE_LAST) begin
					r_next.st = ST_SR_EXIT;
				end
			end
			ST_SR_EXIT: begin
				r_next.st = ST_RUN;
			end
			default: begin
				r_next.st = ST_SR_ENTER;
			end
		endcase
		// interval tracked only at functional clock, so refresh never runs slow
		if (r_next.st == ST_RUN || r_next.st == ST_SR_EXIT) begin
			r_next.ival = refresh_interval;
		end
		r_next.ctl.sr_enter   = (r_next.st == ST_SR_ENTER);
		r_next.ctl.sr_exit    = (r_next.st == ST_SR_EXIT);
		r_next.ctl.clk_bypass = (r_next.st == ST_SR_ENTER) || (r_next.st == ST_BYPASS);
		// clock held off while slow or relocking, lock loss in run ignored
		r_next.ctl.clk_en     = (r_next.st == ST_RUN) || (r_next.st == ST_CLK_ON)
			|| (r_next.st == ST_SR_EXIT);
		r_next.ctl.ready      = (r_next.st == ST_RUN);
		r_next.ctl.refresh    = tick && (r_next.st == ST_RUN) && (r_reg.st == ST_RUN);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r_reg            <= '0;
			r_reg.warm_s1    <= 1'b1;
			r_reg.warm_s2    <= 1'b1;
			r_reg.st         <= ST_RUN;
			r_reg.ival       <= REF_IVAL_RST;
			r_reg.ctl.clk_en <= 1'b1;
			r_reg.ctl.ready  <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign mem_ctl   = r_reg.ctl;
	assign seq_state = r_reg.st;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sr_entry_a: assert property (r_reg.st == ST_RUN && warm_active |=> mem_ctl.sr_enter)
		else $error("no self-refresh entry on warm reset");
	bypass_clock_a: assert property (mem_ctl.sr_enter |=> mem_ctl.clk_bypass
		throughout (warm_active [*2]))
		else $error("clock not in bypass while warm reset held");
	clk_gated_a: assert property (mem_ctl.clk_bypass |-> !mem_ctl.clk_en)
		else $error("slow bypass clock reaches memory");
	release_a: assert property (r_reg.st == ST_BYPASS && !warm_active
		|=> !mem_ctl.clk_bypass && !mem_ctl.clk_en)
		else $error("clock not returned to functional on release");
	exit_late_a: assert property (mem_ctl.sr_exit |-> $past(mem_ctl.clk_en, 1)
		&& $past(mem_ctl.clk_en, 2) && $past(lock_ok, 1))
		else $error("self-refresh exit before stable locked clock");
	exit_run_a: assert property (mem_ctl.sr_exit |=> mem_ctl.ready && mem_ctl.clk_en)
		else $error("no return to operation after exit");
	stable_clk_a: assert property (mem_ctl.ready |-> !mem_ctl.clk_bypass && mem_ctl.clk_en)
		else $error("memory clock changed during operation");
	ival_load_a: assert property (mem_ctl.sr_exit |-> r_reg.ival == $past(refresh_interval))
		else $error("interval not reloaded at exit");
	refresh_run_a: assert property (mem_ctl.refresh |-> mem_ctl.ready && $past(tick))
		else $error("refresh issued outside operation");

endmodule : dwrr_warm_reset_seq

/* File: tb/dwrr_mem_model.sv */
// ddr3 device stand-in that counts command and clock faults
// assumes mem_ctl is sampled on rising ref_clk edges
`timescale 1ns/1ps
module dwrr_mem_model
	import dwrr_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  dwrr_pkg::dwrr_mem_ctl_type mem_ctl,
	output logic                      in_sr,
	output int                        viol
);
	int bad;
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			in_sr <= 1'b0;
			viol  <= 0;
		end else begin
			bad = 0;
			if (mem_ctl.clk_en && mem_ctl.clk_bypass) bad++;
			if (mem_ctl.refresh && in_sr) bad++;
			if (mem_ctl.sr_exit && (!mem_ctl.clk_en || mem_ctl.clk_bypass)) bad++;
			if (mem_ctl.clk_bypass && !in_sr && !mem_ctl.sr_enter) bad++;
			if (mem_ctl.sr_enter) in_sr <= 1'b1;
			if (mem_ctl.sr_exit) in_sr <= 1'b0;
			viol <= viol + bad;
		end
	end
endmodule : dwrr_mem_model

/* File: tb/dwrr_warm_reset_seq_test.sv */
// self-checking bench of the warm-reset refresh sequencer
// assumes the memory stand-in model and the package
`timescale 1ns/1ps
module dwrr_warm_reset_seq_test;
	import dwrr_pkg::*;
	logic ref_clk = 1'b0, resetn = 1'b0, warm_reset_n = 1'b1, pll_lock = 1'b1;
	logic [15:0] ival = 16'h0005;
	dwrr_mem_ctl_type mem_ctl;
	dwrr_state_type   seq_state;
	logic in_sr;
	int   viol, mismatches = 0, n_compared = 0, n;
	logic [31:0] rnd = 32'd41304;
	localparam int SETTLE = 2;
	always #5 ref_clk = ~ref_clk;
	dwrr_warm_reset_seq #(.SETTLE_CYC(SETTLE)) dut (.ref_clk(ref_clk), .resetn(resetn),
		.warm_reset_n(warm_reset_n), .pll_lock(pll_lock), .refresh_interval(ival),
		.mem_ctl(mem_ctl), .seq_state(seq_state));
	dwrr_mem_model mem (.ref_clk(ref_clk), .resetn(resetn), .mem_ctl(mem_ctl),
		.in_sr(in_sr), .viol(viol));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (e !== g) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// cycles until a refresh pulse, bounded
	task automatic wait_ref(output int c);
		c = 0;
		do begin
			@(negedge ref_clk);
			c++;
		end while (mem_ctl.refresh !== 1'b1 && c < 200);
	endtask : wait_ref
	task automatic period(input logic [15:0] iv);
		wait_ref(n);
		wait_ref(n);
		wait_ref(n);
		chk("refresh period", iv + 1, n);
	endtask : period
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		resetn = 1'b1;
		chk("ready after reset", 1, mem_ctl.ready);
		period(ival);
		$display("test refresh done");
		for (int k = 0; k < 3; k++) begin
			rnd = xs(rnd);
			pll_lock = 1'b1;
			warm_reset_n = 1'b0;
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (mem_ctl.sr_enter !== 1'b1 && n < 50);
			chk("sr entry delay", 3, n);
			chk("bypass on", 1, mem_ctl.clk_bypass);
			chk("clock gated", 0, mem_ctl.clk_en);
			pll_lock = 1'b0;
			repeat (4) @(negedge ref_clk);
			chk("state bypass", ST_BYPASS, seq_state);
			chk("self refresh", 1, in_sr);
			ival = 16'(4 + rnd[3:0]);
			warm_reset_n = 1'b1;
			repeat (6) @(negedge ref_clk);
			chk("state relock", ST_RELOCK, seq_state);
			chk("held in sr", 1, in_sr);
			pll_lock = 1'b1;
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (mem_ctl.sr_exit !== 1'b1 && n < 50);
			chk("exit clock on", 1, mem_ctl.clk_en);
			chk("exit delay", 3 + SETTLE, n);
			period(ival);
			$display("test warm reset %0d done", k);
		end
		ival = 16'h0000;
		repeat (30) @(negedge ref_clk);
		wait_ref(n);
		chk("refresh stopped", 200, n);
		chk("device faults", 0, viol);
		$display("test interval zero done");
		wrap_up();
	end
endmodule : dwrr_warm_reset_seq_test
